/* File: caf_pkg.sv */
// shared constants and types for the acceptance filter and status block
package caf_pkg;

    localparam int unsigned CAF_CLK_MHZ = 200;

    // register byte addresses (word aligned)
    localparam logic [7:0] CAF_ADDR_BOCTL    = 8'h00;
    localparam logic [7:0] CAF_ADDR_RXERR    = 8'h04;
    localparam logic [7:0] CAF_ADDR_TXERR    = 8'h08;
    localparam logic [7:0] CAF_ADDR_LAYOUT   = 8'h0C;
    localparam logic [7:0] CAF_ADDR_PAT_BASE = 8'h20;
    localparam logic [7:0] CAF_ADDR_CARE_BASE = 8'h40;

    // field positions
    localparam int unsigned CAF_BUSOFF_HOLD_FLAG_BIT   = 0;
    localparam int unsigned CAF_LAYOUT_LSB   = 4;
    localparam int unsigned CAF_HIT_LSB      = 0;

    // reset values
    localparam logic [7:0] CAF_PAT_RST   = 8'h00;
    localparam logic [7:0] CAF_CARE_RST  = 8'h00;
    localparam logic [1:0] CAF_LAYOUT_RST = 2'h0;
    localparam logic [2:0] CAF_HIT_RST   = 3'h0;

    typedef enum logic [1:0] {
        CAF_LAY_32 = 2'h0,
        CAF_LAY_16 = 2'h1,
        CAF_LAY_8  = 2'h2,
        CAF_LAY_CLOSED = 2'h3
    } caf_layout_t;

    typedef enum logic [1:0] {
        CAF_BO_ACTIVE,
        CAF_BO_HELD,
        CAF_BO_RECOVER
    } caf_bo_state_t;

    // received identifier as stored in the background buffer
    typedef struct packed {
        logic [7:0] ident0;
        logic [7:0] ident1;
        logic [7:0] ident2;
        logic [7:0] ident3;
    } caf_ident_t;

    // operating mode handshakes from the controller
    typedef struct packed {
        logic init_request;
        logic init_acknowledge;
        logic sleep_request;
        logic sleep_acknowledge;
    } caf_mode_t;

endpackage : caf_pkg

/* File: caf_filter_bank.sv */
// eight code and eight care bytes with registered read port
`timescale 1ns/100ps
module caf_filter_bank
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // write port
    input  wire logic        wr_en,
    input  wire logic        wr_care,
    input  wire logic [2:0]  wr_idx,
    input  wire logic [7:0]  wr_data,
    // read port
    input  wire logic        rd_care,
    input  wire logic [2:0]  rd_idx,
    output logic      [7:0]  rd_data,
    // flat view for the comparators
    output logic      [63:0] pat_flat,
    output logic      [63:0] care_flat
);
    import caf_pkg::*;

    logic [7:0] pat_r  [8];
    logic [7:0] care_r [8];
    logic [7:0] pat_nxt  [8];
    logic [7:0] care_nxt [8];
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;

    always_comb
    begin
        pat_nxt  = pat_r;
        care_nxt = care_r;
        if (wr_en && !wr_care)
            pat_nxt[wr_idx] = wr_data;
        if (wr_en && wr_care)
            care_nxt[wr_idx] = wr_data;
        rd_nxt = rd_care ? care_r[rd_idx] : pat_r[rd_idx];
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 8; i++)
            begin
                pat_r[i]  <= CAF_PAT_RST;
                care_r[i] <= CAF_CARE_RST;
            end
            rd_r <= 8'h00;
        end
        else
        begin
            pat_r  <= pat_nxt;
            care_r <= care_nxt;
            rd_r   <= rd_nxt;
        end
    end

    assign rd_data = rd_r;

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_flat
            assign pat_flat[g*8 +: 8]  = pat_r[g];
            assign care_flat[g*8 +: 8] = care_r[g];
        end
    endgenerate

endmodule : caf_filter_bank

/* File: caf_match.sv */
// combinational acceptance decision for one identifier
`timescale 1ns/100ps
module caf_match
(
    // filter setup
    input  wire logic [63:0]        pat_flat,
    input  wire logic [63:0]        care_flat,
    input  wire logic [1:0]         layout,
    // identifier under test
    input  wire caf_pkg::caf_ident_t ident,
    input  wire logic               extended,
    // decision
    output logic                    accept,
    output logic      [2:0]         hit
);
    import caf_pkg::*;

    logic [31:0] id_w;
    logic [7:0]  byte_ok;
    logic [7:0]  half_ok;

    assign id_w = {ident.ident3, ident.ident2, ident.ident1, ident.ident0};

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_byte
            // per-bit compare qualified by care byte
            // care bit 0 needs equality, care bit 1 is don't care
            assign byte_ok[g] = &(~(id_w[(g%4)*8 +: 8]
                ^ pat_flat[g*8 +: 8]) | care_flat[g*8 +: 8]);
            // 16-bit filters all look at the first two ident bytes
            assign half_ok[g] = &(~(id_w[(g%2)*8 +: 8]
                ^ pat_flat[g*8 +: 8]) | care_flat[g*8 +: 8]);
        end
    endgenerate

    always_comb
    begin
        accept = 1'b0;
        hit    = 3'h0;
        case (layout)
            CAF_LAY_32:
            begin
                // all unmasked bits must match
                // standard ids use only the first two bytes
                if (extended ? &byte_ok[3:0] : &byte_ok[1:0])
                begin
                    accept = 1'b1;
                    hit    = 3'h0;
                end
                else if (extended ? &byte_ok[7:4] : &byte_ok[5:4])
                begin
                    accept = 1'b1;
                    hit    = 3'h1;
                end
            end
            CAF_LAY_16:
            begin
                for (int f = 3; f >= 0; f--)
                    if (half_ok[2*f] && half_ok[2*f+1])
                    begin
                        accept = 1'b1;
                        hit    = 3'(f);
                    end
            end
            CAF_LAY_8:
            begin
                for (int f = 7; f >= 0; f--)
                    if (byte_ok[f])
                    begin
                        accept = 1'b1;
                        hit    = 3'(f);
                    end
            end
            default:
            begin
                // closed: nothing accepted
                accept = 1'b0;
                hit    = 3'h0;
            end
        endcase
    end

endmodule : caf_match

/* File: caf_top.sv */
// acceptance filter, bus-off hold and error counter registers of a CAN block
// What this block does
// - with user recovery selected, bus-off sets hold flag and stays until released
// - clearing the hold flag while held starts bus-off recovery
// - hold flag: write one clears, write zero ignored, readable anytime
// - receive error counter is readable in a read-only register
// - transmit error counter is readable in its own read-only register
// - frames go to background buffer; host signalled only when accepted
// - rejected frame is dropped, overwritten by the next one
// - code bits compared with identifier bytes bit for bit
// - in 32-bit layout extended uses four code/care pairs, standard only the first two
// - each compare bit is qualified by its care bit
// - care bit zero demands identifier bit equals code bit
// - care bit one makes that position don't care
// - a filter accepts only if every cared bit matches
// - code and care registers always readable, writable only in init mode
// - layout field: 32-bit, 16-bit, 8-bit filters, or closed
// - hit index names accepting filter, updated on foreground load
`timescale 1ns/100ps
module caf_top
(
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic      [31:0]         prdata,
    output logic                     pslverr,
    // controller mode and recovery selection
    input  wire caf_pkg::caf_mode_t  mode,
    input  wire logic                busoff_recovery_select,
    // protocol engine events
    input  wire logic                busoff_enter,
    input  wire logic                busoff_auto_done,
    input  wire logic [7:0]          rx_fault_cnt,
    input  wire logic [7:0]          tx_fault_cnt,
    // received frame into background buffer
    input  wire logic                frame_valid,
    input  wire caf_pkg::caf_ident_t frame_ident,
    input  wire logic                frame_extended,
    // foreground buffer load from the receive fifo
    input  wire logic                fg_load,
    input  wire logic [2:0]          fg_hit,
    // outputs to the receive path
    output logic                     frame_accept,
    output logic                     frame_drop,
    output logic      [2:0]          accept_hit,
    output logic                     busoff_held,
    output logic                     busoff_recover_req,
    output logic      [2:0]          filter_hit_index
);
    import caf_pkg::*;

    logic        init_mode;
    logic        acc_w;
    logic        acc_r;
    logic        acc_rd;
    logic [7:0]  acc_a;
    logic        bank_sel;
    logic        bank_wr;
    logic        bank_rd_care;
    logic [7:0]  bank_rdata;
    logic [63:0] pat_flat;
    logic [63:0] care_flat;
    logic        m_accept;
    logic [2:0]  m_hit;

    // bus
    logic        pready_r, pready_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic        bank_pend_r, bank_pend_nxt;

    // control state
    caf_bo_state_t bo_r, bo_nxt;
    logic        hold_r, hold_nxt;
    logic        rec_r, rec_nxt;
    logic [1:0]  layout_r, layout_nxt;
    logic [2:0]  hit_idx_r, hit_idx_nxt;
    logic        facc_r, facc_nxt;
    logic        fdrop_r, fdrop_nxt;
    logic [2:0]  ahit_r, ahit_nxt;

    assign init_mode = mode.init_request && mode.init_acknowledge;
    // one wait state, two for bank reads: access taken in first access cycle with pready low
    assign acc_w  = psel && penable && pwrite && !pready_r && !bank_pend_r;
    assign acc_rd = psel && penable && !pwrite && !pready_r && !bank_pend_r;
    assign acc_r  = acc_rd;
    assign acc_a  = paddr;

    assign bank_sel = (paddr >= CAF_ADDR_PAT_BASE)
        && (paddr < CAF_ADDR_CARE_BASE + 8'h20)
        && (paddr[1:0] == 2'h0)
        && ((paddr < CAF_ADDR_PAT_BASE + 8'h20)
            || (paddr >= CAF_ADDR_CARE_BASE));
    assign bank_rd_care = paddr >= CAF_ADDR_CARE_BASE;
    // filter setup is write protected outside init mode
    assign bank_wr = acc_w && bank_sel && init_mode;

    caf_filter_bank u_bank
    (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .wr_en     (bank_wr),
        .wr_care   (bank_rd_care),
        .wr_idx    (paddr[4:2]),
        .wr_data   (pwdata[7:0]),
        .rd_care   (bank_rd_care),
        .rd_idx    (paddr[4:2]),
        .rd_data   (bank_rdata),
        .pat_flat  (pat_flat),
        .care_flat (care_flat)
    );

    caf_match u_match
    (
        .pat_flat  (pat_flat),
        .care_flat (care_flat),
        .layout    (layout_r),
        .ident     (frame_ident),
        .extended  (frame_extended),
        .accept    (m_accept),
        .hit       (m_hit)
    );

    // apb response
    always_comb
    begin
        pready_nxt    = 1'b0;
        prdata_nxt    = prdata_r;
        pslverr_nxt   = 1'b0;
        bank_pend_nxt = 1'b0;
        if (acc_w || acc_rd)
        begin
            pready_nxt = 1'b1;
            prdata_nxt = 32'h0000_0000;
            if (acc_a == CAF_ADDR_BOCTL)
            begin
                if (acc_rd)
                    prdata_nxt[CAF_BUSOFF_HOLD_FLAG_BIT] = hold_r;
            end
            else if (acc_a == CAF_ADDR_RXERR)
            begin
                if (acc_rd)
                    prdata_nxt[7:0] = rx_fault_cnt;
            end
            else if (acc_a == CAF_ADDR_TXERR)
            begin
                if (acc_rd)
                    prdata_nxt[7:0] = tx_fault_cnt;
            end
            else if (acc_a == CAF_ADDR_LAYOUT)
            begin
                if (acc_rd)
                begin
                    prdata_nxt[CAF_LAYOUT_LSB +: 2] = layout_r;
                    prdata_nxt[CAF_HIT_LSB +: 3]    = hit_idx_r;
                end
            end
            else if (bank_sel)
            begin
                // bank read data arrives one cycle later
                pready_nxt    = !acc_rd;
                bank_pend_nxt = acc_rd;
            end
            else
            begin
                pslverr_nxt = 1'b1;
            end
        end
        if (bank_pend_r)
        begin
            pready_nxt = 1'b1;
            prdata_nxt = {24'h000000, bank_rdata};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pready_r    <= 1'b0;
            prdata_r    <= 32'h0000_0000;
            pslverr_r   <= 1'b0;
            bank_pend_r <= 1'b0;
        end
        else
        begin
            pready_r    <= pready_nxt;
            prdata_r    <= prdata_nxt;
            pslverr_r   <= pslverr_nxt;
            bank_pend_r <= bank_pend_nxt;
        end
    end

    // bus-off hold, layout, receive decision
    always_comb
    begin
        bo_nxt      = bo_r;
        hold_nxt    = hold_r;
        rec_nxt     = 1'b0;
        layout_nxt  = layout_r;
        hit_idx_nxt = hit_idx_r;
        facc_nxt    = 1'b0;
        fdrop_nxt   = 1'b0;
        ahit_nxt    = ahit_r;
        // automatic recovery when user recovery is not selected
        if (bo_r == CAF_BO_ACTIVE && busoff_auto_done)
            hold_nxt = 1'b0;
        case (bo_r)
            CAF_BO_ACTIVE, CAF_BO_RECOVER:
            begin
                bo_nxt = CAF_BO_ACTIVE;
                if (busoff_enter && busoff_recovery_select)
                begin
                    bo_nxt   = CAF_BO_HELD;
                    hold_nxt = 1'b1;
                end
            end
            CAF_BO_HELD:
            begin
                // write one clears; zero ignored
                if (acc_w && acc_a == CAF_ADDR_BOCTL
                    && pwdata[CAF_BUSOFF_HOLD_FLAG_BIT])
                begin
                    hold_nxt = 1'b0;
                    rec_nxt  = 1'b1;
                    bo_nxt   = CAF_BO_RECOVER;
                end
            end
            default:
            begin
                bo_nxt = CAF_BO_ACTIVE;
            end
        endcase
        if (acc_w && acc_a == CAF_ADDR_LAYOUT && init_mode)
            layout_nxt = pwdata[CAF_LAYOUT_LSB +: 2];
        // background frame judged; rejects simply get overwritten
        if (frame_valid)
        begin
            facc_nxt  = m_accept;
            fdrop_nxt = !m_accept;
            ahit_nxt  = m_hit;
        end
        if (fg_load)
            hit_idx_nxt = fg_hit;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            bo_r      <= CAF_BO_ACTIVE;
            hold_r    <= 1'b0;
            rec_r     <= 1'b0;
            layout_r  <= CAF_LAYOUT_RST;
            hit_idx_r <= CAF_HIT_RST;
            facc_r    <= 1'b0;
            fdrop_r   <= 1'b0;
            ahit_r    <= CAF_HIT_RST;
        end
        else
        begin
            bo_r      <= bo_nxt;
            hold_r    <= hold_nxt;
            rec_r     <= rec_nxt;
            layout_r  <= layout_nxt;
            hit_idx_r <= hit_idx_nxt;
            facc_r    <= facc_nxt;
            fdrop_r   <= fdrop_nxt;
            ahit_r    <= ahit_nxt;
        end
    end

    assign pready             = pready_r;
    assign prdata             = prdata_r;
    assign pslverr            = pslverr_r;
    assign frame_accept       = facc_r;
    assign frame_drop         = fdrop_r;
    assign accept_hit         = ahit_r;
    assign busoff_held        = hold_r;
    assign busoff_recover_req = rec_r;
    assign filter_hit_index   = hit_idx_r;

endmodule : caf_top

/* File: caf_top_sva.sv */
// port assertions for the acceptance filter and status block
`timescale 1ns/100ps
module caf_top_sva
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        sys_rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    // engine side
    input wire logic        busoff_recovery_select,
    input wire logic        busoff_enter,
    input wire logic [7:0]  rx_fault_cnt,
    input wire logic [7:0]  tx_fault_cnt,
    input wire logic        frame_valid,
    input wire logic        fg_load,
    input wire logic [2:0]  fg_hit,
    // results
    input wire logic        frame_accept,
    input wire logic        frame_drop,
    input wire logic        busoff_held,
    input wire logic        busoff_recover_req,
    input wire logic [2:0]  filter_hit_index
);
    import caf_pkg::*;
    logic clr_take;
    logic rd_done;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // a one written to the hold flag is taken at the first access edge
    assign clr_take = psel && penable && pwrite && !pready
                      && paddr == CAF_ADDR_BOCTL && pwdata[0];
    assign rd_done = psel && penable && !pwrite && pready;
    sequence s_release;
        busoff_held && clr_take;
    endsequence
    chk_hold_set: assert property (
        busoff_enter && busoff_recovery_select |=> busoff_held)
        else $error("hold flag not set on bus-off");
    chk_hold_keep: assert property (
        busoff_held && !clr_take |=> busoff_held)
        else $error("hold flag dropped without release");
    chk_release_req: assert property (
        s_release |=> busoff_recover_req && !busoff_held
        ##1 !busoff_recover_req)
        else $error("release did not raise one recovery pulse");
    chk_frame_judged: assert property (
        frame_valid |=> frame_accept != frame_drop)
        else $error("frame neither accepted nor dropped once");
    chk_frame_quiet: assert property (
        !frame_valid |=> !frame_accept && !frame_drop)
        else $error("verdict without a frame");
    chk_hit_load: assert property (
        fg_load |=> filter_hit_index == $past(fg_hit))
        else $error("hit index not loaded");
    chk_hit_hold: assert property (
        !fg_load |=> $stable(filter_hit_index))
        else $error("hit index moved without load");
    chk_boctl_read: assert property (
        rd_done && paddr == CAF_ADDR_BOCTL |->
        prdata == {31'h0, busoff_held})
        else $error("bus-off control read wrong");
    chk_count_read: assert property (
        rd_done && (paddr == CAF_ADDR_RXERR || paddr == CAF_ADDR_TXERR)
        |-> prdata[7:0] == (paddr == CAF_ADDR_TXERR ? tx_fault_cnt
        : rx_fault_cnt))
        else $error("error counter read wrong");
endmodule : caf_top_sva

/* File: caf_engine_model.sv */
// behavioural protocol engine feeding the filter block
`timescale 1ns/100ps
module caf_engine_model
(
    // clock
    input  wire logic          mclk,
    // events and counters
    output logic               busoff_enter,
    output logic               busoff_auto_done,
    output logic [7:0]         rx_fault_cnt,
    output logic [7:0]         tx_fault_cnt,
    // frames and foreground
    output logic               frame_valid,
    output caf_pkg::caf_ident_t frame_ident,
    output logic               frame_extended,
    output logic               fg_load,
    output logic [2:0]         fg_hit
);
    import caf_pkg::*;
    initial
    begin
        busoff_enter = 1'b0;
        busoff_auto_done = 1'b0;
        rx_fault_cnt = 8'h00;
        tx_fault_cnt = 8'h00;
        frame_valid = 1'b0;
        frame_ident = '1;
        frame_extended = 1'b0;
        fg_load = 1'b0;
        fg_hit = 3'h0;
    end
    task automatic send_frame(input caf_ident_t id, input logic ext);
        @(posedge mclk);
        frame_valid <= 1'b1;
        frame_ident <= id;
        frame_extended <= ext;
        @(posedge mclk);
        frame_valid <= 1'b0;
        // identifier means nothing outside its strobe
        frame_ident <= ~id;
        frame_extended <= ~ext;
    endtask : send_frame
    task automatic pulse(input logic bo, input logic ad);
        @(posedge mclk);
        busoff_enter <= bo;
        busoff_auto_done <= ad;
        @(posedge mclk);
        busoff_enter <= 1'b0;
        busoff_auto_done <= 1'b0;
    endtask : pulse
    task automatic load_fg(input logic [2:0] h);
        @(posedge mclk);
        fg_load <= 1'b1;
        fg_hit <= h;
        @(posedge mclk);
        fg_load <= 1'b0;
        fg_hit <= ~h;
    endtask : load_fg
    task automatic set_cnt(input logic [7:0] r, input logic [7:0] t);
        @(posedge mclk);
        rx_fault_cnt <= r;
        tx_fault_cnt <= t;
    endtask : set_cnt
endmodule : caf_engine_model

/* File: testbench.sv */
// self-checking bench for the acceptance filter and status block
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
    errors++; $display("wrong value %s exp %0h seen %0h", nm, ex, gt); \
    end end
module testbench;
    import caf_pkg::*;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdq;
    logic        pready, pslverr, rde;
    caf_mode_t   mode = 4'h0;
    logic        busoff_recovery_select = 1'b0;
    logic        busoff_enter, busoff_auto_done, frame_valid;
    logic        frame_extended, fg_load, frame_accept, frame_drop;
    logic        busoff_held, busoff_recover_req;
    logic [7:0]  rx_fault_cnt, tx_fault_cnt;
    logic [2:0]  fg_hit, accept_hit, filter_hit_index;
    caf_ident_t  frame_ident;
    logic [7:0]  pat_m [8];
    logic [7:0]  care_m [8];
    int          errors = 0;
    int          n_tests = 0;

    always #2.5 mclk = ~mclk;

    caf_top dut_u (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .mode, .busoff_recovery_select,
        .busoff_enter, .busoff_auto_done, .rx_fault_cnt, .tx_fault_cnt,
        .frame_valid, .frame_ident, .frame_extended, .fg_load, .fg_hit,
        .frame_accept, .frame_drop, .accept_hit, .busoff_held,
        .busoff_recover_req, .filter_hit_index);
    caf_engine_model eng_u (.mclk, .busoff_enter, .busoff_auto_done,
        .rx_fault_cnt, .tx_fault_cnt, .frame_valid, .frame_ident,
        .frame_extended, .fg_load, .fg_hit);

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        rdq = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16)
        begin
            errors++;
            close_out();
        end
    endtask : apb

    task automatic set_mode(input logic [3:0] m);
        @(posedge mclk);
        mode <= m;
    endtask : set_mode

    function automatic int exp_hit(logic [1:0] lay, logic ext,
                                   caf_ident_t id);
        int nb;
        int i;
        int k;
        logic ok;
        if (lay == 2'h3)
            return -1;
        nb = (lay == 2'h0) ? 4 : (lay == 2'h1) ? 2 : 1;
        for (int f = 0; f < 8 / nb; f++)
        begin
            ok = 1'b1;
            for (int b = 0; b < nb; b++)
            begin
                k = f * nb + b;
                i = (nb == 1) ? f % 4 : b;
                if (ext || i < 2)
                    if (((id[31 - 8 * i -: 8] ^ pat_m[k]) & ~care_m[k])
                        != 8'h00)
                        ok = 1'b0;
            end
            if (ok)
                return f;
        end
        return -1;
    endfunction : exp_hit

    initial
    begin
        repeat (50000) @(posedge mclk);
        errors++;
        close_out();
    end

    initial
    begin
        caf_ident_t id;
        logic [1:0] lay;
        logic       ext;
        int         f, h, k, i;
        void'($urandom(56));
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int n = 0; n < 16; n++)
        begin
            apb(1'b0, CAF_ADDR_PAT_BASE + 8'(4 * n), 32'h0);
            `CHK("bank reset", 32'h0, rdq)
        end
        apb(1'b0, CAF_ADDR_LAYOUT, 32'h0);
        `CHK("layout reset", 32'h0, rdq)
        apb(1'b1, CAF_ADDR_PAT_BASE, 32'hA5);
        apb(1'b0, CAF_ADDR_PAT_BASE, 32'h0);
        `CHK("locked pattern", 32'h0, rdq)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 1'b1, rde)
        for (int m = 0; m < 2; m++)
        begin
            set_mode(m ? 4'hC : 4'h3);
            eng_u.set_cnt(8'($urandom), 8'($urandom));
            apb(1'b1, CAF_ADDR_RXERR, 32'hFF);
            apb(1'b0, CAF_ADDR_RXERR, 32'h0);
            `CHK("rx count", {24'h0, rx_fault_cnt}, rdq)
            apb(1'b1, CAF_ADDR_TXERR, 32'h0);
            apb(1'b0, CAF_ADDR_TXERR, 32'h0);
            `CHK("tx count", {24'h0, tx_fault_cnt}, rdq)
        end
        busoff_recovery_select <= 1'b1;
        eng_u.pulse(1'b1, 1'b0);
        @(posedge mclk);
        `CHK("hold set", 1'b1, busoff_held)
        apb(1'b1, CAF_ADDR_BOCTL, 32'hFFFF_FFFE);
        apb(1'b0, CAF_ADDR_BOCTL, 32'h0);
        `CHK("hold kept", 32'h1, rdq)
        apb(1'b1, CAF_ADDR_BOCTL, 32'h1);
        @(posedge mclk);
        `CHK("hold freed", 1'b0, busoff_held)
        eng_u.pulse(1'b0, 1'b1);
        apb(1'b0, CAF_ADDR_BOCTL, 32'h0);
        `CHK("hold idle", 32'h0, rdq)
        for (int l = 0; l < 4; l++)
        begin
            lay = 2'(l);
            set_mode(4'hC);
            apb(1'b1, CAF_ADDR_LAYOUT, 32'(lay) << 4);
            for (int n = 0; n < 8; n++)
            begin
                pat_m[n] = 8'($urandom);
                care_m[n] = 8'($urandom & $urandom);
            end
            for (int n = 1; n < 8; n += 2)
                if (lay == 2'h1 || n % 4 == 1)
                    care_m[n][2:0] = 3'h7;
            for (int n = 0; n < 16; n++)
                apb(1'b1, CAF_ADDR_PAT_BASE + 8'(4 * n),
                    {24'h0, n < 8 ? pat_m[n] : care_m[n - 8]});
            set_mode(4'h0);
            apb(1'b0, CAF_ADDR_CARE_BASE + 8'h14, 32'h0);
            `CHK("care read", {24'h0, care_m[5]}, rdq)
            for (int t = 0; t < 24; t++)
            begin
                f = $urandom_range(7);
                ext = (lay == 2'h2) ? 1'b1 : 1'($urandom);
                id = caf_ident_t'($urandom);
                for (int b = 0; b < 4 && t % 2 == 0; b++)
                begin
                    k = lay == 2'h1 ? (f % 4) * 2 + b : (f % 2) * 4 + b;
                    k = lay == 2'h2 ? f : k;
                    i = lay == 2'h2 ? f % 4 : b;
                    if (lay != 2'h1 || b < 2)
                        id[31 - 8 * i -: 8] = pat_m[k]
                            ^ (8'($urandom) & care_m[k]);
                end
                eng_u.send_frame(id, ext);
                @(posedge mclk);
                h = exp_hit(lay, ext, id);
                `CHK("accepted", h >= 0, frame_accept)
                `CHK("dropped", h < 0, frame_drop)
                if (h >= 0)
                    `CHK("hit", 3'(h), accept_hit)
            end
        end
        for (int t = 0; t < 4; t++)
        begin
            h = $urandom_range(7);
            eng_u.load_fg(3'(h));
            @(posedge mclk);
            `CHK("fg hit", 3'(h), filter_hit_index)
            apb(1'b0, CAF_ADDR_LAYOUT, 32'h0);
            `CHK("hit reg", 3'(h), rdq[2:0])
        end
        close_out();
    end
endmodule : testbench

bind caf_top caf_top_sva chk_u (.mclk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .busoff_recovery_select,
    .busoff_enter, .rx_fault_cnt, .tx_fault_cnt, .frame_valid, .fg_load,
    .fg_hit, .frame_accept, .frame_drop, .busoff_held, .busoff_recover_req,
    .filter_hit_index);
